// ### logic/lds_pkg.sv
/*
  Shared constants, states and carriers for the LED dimming fault sequencer.
  Assumes a single 200 MHz clock and comparator results arriving as digital levels.
*/
package lds_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int CLAMP_MS = 10;
  localparam int CLAMP_CYC = CLAMP_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int RECON_NS = 2400;
  localparam int RECON_CYC = (RECON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FMAX_KHZ = 350;
  localparam int MIN_HALF_CYC = (1_000_000 + 2 * FMAX_KHZ * CLK_PERIOD_NS - 1) / (2 * FMAX_KHZ * CLK_PERIOD_NS);

  localparam int CNT_W = 22;
  localparam int RC_W = 9;
  localparam int HALF_W = 9;
  localparam int LVL_INT_W = 12;
  localparam int LVL_FRAC = 8;
  localparam int LVL_W = LVL_INT_W + LVL_FRAC;
  localparam int LVL_SHIFT = 8;
  localparam int TICK_W = 12;
  localparam logic [LVL_INT_W-1:0] LVL_LO_MV = 12'h064;
  localparam logic [LVL_INT_W-1:0] LVL_HI_MV = 12'hA28;

  localparam int AXI_ADDR_W = 32;
  localparam int DEC_W = 4;
  localparam logic [DEC_W-1:0] REG_CTRL = 4'h0;
  localparam logic [DEC_W-1:0] REG_STATUS = 4'h4;
  localparam logic [DEC_W-1:0] REG_LEVEL = 4'h8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_IN_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    ST_OFF   = 6'h01,
    ST_CLAMP = 6'h02,
    ST_SOFT  = 6'h04,
    ST_RUN   = 6'h08,
    ST_FAULT = 6'h10,
    ST_LATCH = 6'h20
  } lds_state_t;

  // Comparator and pin levels, all active high
  typedef struct packed {
    logic brightness_pwm_in;
    logic backlight_on_in;
    logic supply_lockout;
    logic output_high_limit_sense;
    logic output_low_limit_sense;
    logic cl_restart_trip;
    logic cl_release_ok;
    logic cl_latch_trip;
    logic soft_start_done;
    logic duty_adjust_cross;
    logic slew_above_enable;
    logic osc_phase;
  } lds_sense_t;

  localparam int SENSE_W = $bits(lds_sense_t);

  typedef struct packed {
    lds_state_t st;
    logic pwm_prev;
    logic [CNT_W-1:0] clamp_cnt;
    logic sw;
    logic drv_a;
    logic drv_b;
    logic ramp_en;
    logic pso;
    logic ss_en;
    logic lcc;
    logic [RC_W-1:0] on_cnt;
    logic phase;
    logic [HALF_W-1:0] half_cnt;
    logic [LVL_W-1:0] lvl;
    logic [TICK_W-1:0] tick_cnt;
    logic [31:0] ctrl;
    logic aw_got;
    logic [DEC_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lds_core_t;

  typedef struct packed {
    lds_sense_t s1;
    lds_sense_t s2;
    lds_sense_t s3;
    lds_sense_t out;
  } lds_sync_t;

endpackage

// ### logic/lds_pin_sync.sv
/*
  Three-stage synchroniser for the comparator and pin levels.
  Assumes inputs are asynchronous to aclk; output changes once stages two and three agree.
*/
`timescale 1ns/100ps
module lds_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire lds_pkg::lds_sense_t pins_async,
  output lds_pkg::lds_sense_t pins_sync
);
  import lds_pkg::*;

  lds_sync_t q;
  lds_sync_t n;

  always_comb begin
    n = q;
    n.s1 = pins_async;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.out = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.out);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign pins_sync = q.out;
endmodule

// ### logic/lds_sequencer.sv
/*
  Dimming and fault sequencer with an AXI4-Lite register slave.
  Assumes analog comparators outside; their results enter through lds_pin_sync.
*/
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module lds_sequencer #(
  parameter int unsigned CLAMP_CYCLES = lds_pkg::CLAMP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire lds_pkg::lds_sense_t sense_pins,
  output logic string_switch_out,
  output logic half_bridge_drive_a,
  output logic half_bridge_drive_b,
  output logic duty_adjust_ramp_en,
  output logic power_stage_off,
  output logic soft_start_charge_en,
  output logic loop_comp_connect,
  output logic [lds_pkg::LVL_INT_W-1:0] duty_average_level,
  input wire logic [lds_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lds_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import lds_pkg::*;

  localparam lds_core_t CORE_RST = '{st: ST_OFF, ctrl: CTRL_RST, default: '0};
  localparam logic [CNT_W-1:0] CLAMP_LAST = CNT_W'(CLAMP_CYCLES - 1);
  localparam logic [RC_W-1:0] RECON_LAST = RC_W'(RECON_CYC);
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(MIN_HALF_CYC - 1);
  localparam int AST_RC = RECON_CYC;

  lds_sense_t s;
  lds_core_t q;
  lds_core_t n;
  logic pwm_rise;
  logic pwm_fall;
  logic start_ok;
  logic gate_en;
  logic [LVL_INT_W-1:0] tgt;
  logic signed [LVL_W+1:0] diff;
  logic [DEC_W-1:0] ardec;

  // Mapped register check, shared by write and read paths
  function automatic logic reg_mapped(input logic [DEC_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_LEVEL);
  endfunction

  lds_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins_async(sense_pins),
    .pins_sync(s)
  );

  assign ardec = s_axi_araddr[DEC_W-1:0];

  always_comb begin
    n = q;
    pwm_rise = s.brightness_pwm_in & ~q.pwm_prev;
    pwm_fall = ~s.brightness_pwm_in & q.pwm_prev;
    n.pwm_prev = s.brightness_pwm_in;
    start_ok = ~s.supply_lockout & s.backlight_on_in & q.ctrl[CTRL_EN_BIT];
    gate_en = 1'b0;
    tgt = '0;
    diff = '0;

    // Sequencing
    unique case (q.st)
      ST_OFF: begin
        if (start_ok) begin
          n.st = ST_CLAMP;
          n.clamp_cnt = '0;
        end
      end
      ST_CLAMP: begin
        if (q.clamp_cnt == CLAMP_LAST) begin
          n.st = ST_SOFT;
        end else begin
          n.clamp_cnt = q.clamp_cnt + 1'b1;
        end
      end
      ST_SOFT: begin
        if (s.soft_start_done) begin
          n.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (s.output_low_limit_sense) begin
          n.st = ST_CLAMP;
          n.clamp_cnt = '0;
        end
      end
      ST_FAULT: begin
        if (~s.output_high_limit_sense & ~s.cl_restart_trip & s.cl_release_ok) begin
          n.st = ST_CLAMP;
          n.clamp_cnt = '0;
        end
      end
      ST_LATCH: begin
      end
    endcase

    // Restartable faults, then start loss, supply lockout and latched fault
    if ((q.st == ST_CLAMP || q.st == ST_SOFT || q.st == ST_RUN) &&
        (s.output_high_limit_sense || s.cl_restart_trip)) begin
      n.st = ST_FAULT;
    end
    if (!start_ok && q.st != ST_LATCH) begin
      n.st = ST_OFF;
    end
    if (s.supply_lockout) begin
      n.st = ST_OFF;
    end else if (s.cl_latch_trip) begin
      n.st = ST_LATCH;
    end

    // String switch
    unique case (n.st)
      ST_RUN: n.sw = s.brightness_pwm_in;
      ST_SOFT: n.sw = 1'b1;
      default: n.sw = 1'b0;
    endcase

    // Dimming edges, ramp and power-stage-off
    if (n.st == ST_RUN) begin
      if (q.st != ST_RUN) begin
        n.ramp_en = ~s.brightness_pwm_in;
        n.pso = ~s.brightness_pwm_in;
      end else begin
        if (q.ramp_en && s.duty_adjust_cross) begin
          n.pso = 1'b0;
        end
        if (pwm_rise) begin
          n.ramp_en = 1'b0;
        end
        if (pwm_fall) begin
          n.ramp_en = 1'b1;
          n.pso = 1'b1;
        end
      end
    end else begin
      n.ramp_en = 1'b0;
      n.pso = 1'b0;
    end

    // Gate drive enable and phase rate limit
    gate_en = (n.st == ST_SOFT) || (n.st == ST_RUN && !n.pso && s.slew_above_enable);
    if (q.half_cnt != HALF_LAST) begin
      n.half_cnt = q.half_cnt + 1'b1;
    end
    if (s.osc_phase != q.phase && q.half_cnt == HALF_LAST) begin
      n.phase = s.osc_phase;
      n.half_cnt = '0;
    end
    n.drv_a = gate_en & n.phase;
    n.drv_b = gate_en & ~n.phase;
    n.ss_en = (n.st == ST_SOFT) || (n.st == ST_RUN);

    // Loop compensation reconnect delay
    if (!n.sw) begin
      n.on_cnt = '0;
    end else if (q.on_cnt != RECON_LAST) begin
      n.on_cnt = q.on_cnt + 1'b1;
    end
    n.lcc = n.sw && (n.on_cnt == RECON_LAST);

    // Duty-average level filter
    n.tick_cnt = q.tick_cnt + 1'b1;
    tgt = s.brightness_pwm_in ? LVL_LO_MV : LVL_HI_MV;
    diff = $signed({2'b00, tgt, {LVL_FRAC{1'b0}}}) - $signed({2'b00, q.lvl});
    if (q.tick_cnt == '0) begin
      n.lvl = LVL_W'($signed({2'b00, q.lvl}) + (diff >>> LVL_SHIFT));
    end

    // AXI4-Lite write path
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr[DEC_W-1:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = reg_mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (q.awaddr == REG_CTRL) begin
        for (int i = 0; i < 4; i++) begin
          if (q.wstrb[i]) begin
            n.ctrl[8*i +: 8] = q.wdata[8*i +: 8];
          end
        end
        n.ctrl = n.ctrl & CTRL_MASK;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // AXI4-Lite read path
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = reg_mapped(ardec) ? RESP_OKAY : RESP_SLVERR;
      n.rdata = '0;
      if (ardec == REG_CTRL) begin
        n.rdata = q.ctrl;
      end else if (ardec == REG_STATUS) begin
        n.rdata[STAT_ST_LSB +: 6] = q.st;
        n.rdata[STAT_IN_LSB +: SENSE_W] = s;
      end else if (ardec == REG_LEVEL) begin
        n.rdata[LVL_INT_W-1:0] = q.lvl[LVL_W-1:LVL_FRAC];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= CORE_RST;
    end else begin
      q <= n;
    end
  end

  assign string_switch_out = q.sw;
  assign half_bridge_drive_a = q.drv_a;
  assign half_bridge_drive_b = q.drv_b;
  assign duty_adjust_ramp_en = q.ramp_en;
  assign power_stage_off = q.pso;
  assign soft_start_charge_en = q.ss_en;
  assign loop_comp_connect = q.lcc;
  assign duty_average_level = q.lvl[LVL_W-1:LVL_FRAC];
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // Consecutive switch-on cycles seen by the checks
  logic [RC_W-1:0] ast_on_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || !q.sw) begin
      ast_on_ff <= '0;
    end else if (ast_on_ff != '1) begin
      ast_on_ff <= ast_on_ff + 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_run_fall;
    q.st == ST_RUN && pwm_fall && !s.supply_lockout && !s.cl_latch_trip &&
    !s.output_high_limit_sense && !s.cl_restart_trip && !s.output_low_limit_sense && start_ok;
  endsequence

  sequence s_switch_rise;
    $rose(q.sw) ##1 q.sw [*1];
  endsequence

  AST_SWITCH_FOLLOWS_PWM: assert property (
    q.st == ST_RUN && $past(q.st) == ST_RUN |-> q.sw == $past(s.brightness_pwm_in))
    else $error("String switch does not follow PWM in run");
  AST_SOFT_HOLDS_HIGH: assert property (
    q.st == ST_SOFT |-> q.sw)
    else $error("String switch low during soft start");
  AST_FAULT_SWITCH_LOW: assert property (
    q.st inside {ST_FAULT, ST_LATCH, ST_CLAMP, ST_OFF} |-> !q.sw && !q.drv_a && !q.drv_b)
    else $error("Switch or drive active while stopped");
  AST_HIGH_LIMIT_STOPS: assert property (
    q.st == ST_RUN && s.output_high_limit_sense && !s.supply_lockout && !s.cl_latch_trip && start_ok
    |=> q.st == ST_FAULT && !q.sw && !q.drv_a && !q.drv_b)
    else $error("High-limit fault not acted on");
  AST_LOW_LIMIT_IGNORED_SOFT: assert property (
    q.st == ST_SOFT && s.output_low_limit_sense && !s.soft_start_done && start_ok &&
    !s.output_high_limit_sense && !s.cl_restart_trip && !s.cl_latch_trip |=> q.st == ST_SOFT)
    else $error("Low-limit acted on during soft start");
  AST_LATCH_HOLDS: assert property (
    q.st == ST_LATCH && !s.supply_lockout |=> q.st == ST_LATCH)
    else $error("Latched fault released without lockout");
  AST_FALL_SETS_OFF: assert property (
    s_run_fall |=> q.pso && q.ramp_en)
    else $error("PWM fall did not set power-stage-off and ramp");
  AST_OFF_HOLDS: assert property (
    q.st == ST_RUN && q.pso && !(q.ramp_en && s.duty_adjust_cross) && n.st == ST_RUN |=> q.pso)
    else $error("Power-stage-off released before crossing");
  AST_GATE_NEEDS_SLEW: assert property (
    q.st == ST_RUN && (q.drv_a || q.drv_b) |-> $past(s.slew_above_enable) && !q.pso)
    else $error("Gate drive without slew enable");
  AST_RECONNECT_DELAY: assert property (
    q.sw && ast_on_ff >= RC_W'(AST_RC - 1) |-> q.lcc)
    else $error("Loop reconnect late");
  AST_RECONNECT_NOT_AT_RISE: assert property (
    s_switch_rise |-> !q.lcc)
    else $error("Loop reconnect at switch turn-on");
  AST_RECONNECT_NOT_EARLY: assert property (
    $rose(q.lcc) |-> q.on_cnt == RECON_LAST && $past(q.sw, 2))
    else $error("Loop reconnect early");
endmodule

// ### verif/lds_plant_model.sv
/*
  Model of the analog far side: soft-start, duty-adjust and slew ramps as cycle counts.
  Assumes aclk as time base; its outputs are levels that the design synchronises.
*/
`timescale 1ns/100ps
module lds_plant_model #(
  parameter int SS_CYC = 80,
  parameter int ADJ_CYC = 40,
  parameter int SLEW_CYC = 30
) (
  input wire logic aclk,
  input wire logic ss_charge,
  input wire logic ramp_en,
  input wire logic sw_on,
  output logic ss_done,
  output logic adj_cross,
  output logic slew_above
);
  int ss_cnt = 0;
  int adj_cnt = 0;
  int slew_cnt = 0;
  // Each ramp restarts from zero when its source drops
  always @(posedge aclk) begin
    ss_cnt <= ss_charge ? ss_cnt + 1 : 0;
    adj_cnt <= ramp_en ? adj_cnt + 1 : 0;
    slew_cnt <= sw_on ? slew_cnt + 1 : 0;
  end
  assign ss_done = (ss_cnt >= SS_CYC);
  assign adj_cross = (adj_cnt >= ADJ_CYC);
  assign slew_above = (slew_cnt >= SLEW_CYC);
endmodule

// ### verif/lds_sequencer_bench.sv
/*
  Self-checking bench for the dimming and fault sequencer.
  Assumes the plant model closes the soft-start, duty-adjust and slew ramps.
*/
`timescale 1ns/100ps
module lds_sequencer_bench;
  import lds_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  lds_sense_t pins = '0;
  lds_sense_t sense;
  logic sw, drv_a, drv_b, ramp, pso, ss_en, lcc, ss_done, adj_cross, slew_above;
  logic [11:0] lvl;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int fail_count = 0;
  int tests_run = 0;

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  always_comb begin
    sense = pins;
    sense.soft_start_done = ss_done;
    sense.duty_adjust_cross = adj_cross;
    sense.slew_above_enable = slew_above;
  end

  lds_sequencer #(.CLAMP_CYCLES(200)) u_lds_sequencer (
    .aclk(aclk), .aresetn(aresetn), .sense_pins(sense), .string_switch_out(sw),
    .half_bridge_drive_a(drv_a), .half_bridge_drive_b(drv_b), .duty_adjust_ramp_en(ramp),
    .power_stage_off(pso), .soft_start_charge_en(ss_en), .loop_comp_connect(lcc),
    .duty_average_level(lvl), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  lds_plant_model u_lds_plant_model (
    .aclk(aclk), .ss_charge(ss_en), .ramp_en(ramp), .sw_on(sw),
    .ss_done(ss_done), .adj_cross(adj_cross), .slew_above(slew_above)
  );

  task automatic finish_test();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic hang();
    fail_count++;
    $display("Error at %0t: wait ran out", $time);
    finish_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_pwr(input logic s, input logic d);
    chk_bit(sw, s, "string switch");
    chk_bit(drv_a | drv_b, d, "bridge drive");
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    if (!tb) hang();
    cyc(1);
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !tr; n++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    if (!tr) hang();
    cyc(1);
  endtask

  task automatic wait_state(input lds_state_t s);
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 0; n < 150; n++) begin
      axi_rd({28'h000_0000, REG_STATUS}, d, r);
      if (d[5:0] === s) break;
    end
    chk_word({26'h0, d[5:0]}, {26'h0, s}, "state");
    if (d[5:0] !== s) hang();
  endtask

  task automatic sc_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk_bit(sw | drv_a | drv_b | ramp | pso | ss_en | lcc, 1'b0, "outputs idle");
    chk_word({20'h0, lvl}, {20'h0, LVL_HI_MV >> LVL_SHIFT}, "duty level");
    axi_rd({28'h000_0000, REG_CTRL}, d, r);
    chk_word(d, CTRL_RST, "ctrl reset");
    axi_rd(32'h0000_000C, d, r);
    chk_word({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    axi_wr(32'h0000_000C, 32'h0000_0001, r);
    chk_word({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_wr({28'h000_0000, REG_STATUS}, 32'h0000_0000, r);
    chk_word({30'h0, r}, {30'h0, RESP_OKAY}, "status write");
    wait_state(ST_OFF);
  endtask

  task automatic sc_start();
    pins.osc_phase <= 1'b1;
    pins.cl_release_ok <= 1'b1;
    pins.output_low_limit_sense <= 1'b1;
    pins.backlight_on_in <= 1'b1;
    wait_state(ST_CLAMP);
    chk_pwr(1'b0, 1'b0);
    cyc(150);
    wait_state(ST_CLAMP);
    wait_state(ST_SOFT);
    chk_pwr(1'b1, 1'b1);
    cyc(20);
    wait_state(ST_SOFT);
    chk_bit(sw, 1'b1, "switch in soft");
    pins.output_low_limit_sense <= 1'b0;
    wait_state(ST_RUN);
  endtask

  task automatic sc_dim();
    cyc(50);
    chk_bit(pso, 1'b0, "off released at entry");
    pins.brightness_pwm_in <= 1'b1;
    cyc(10);
    chk_pwr(1'b1, 1'b0);
    cyc(40);
    chk_bit(drv_a | drv_b, 1'b1, "drive after slew");
    cyc(410);
    chk_bit(lcc, 1'b0, "comp early");
    cyc(40);
    chk_bit(lcc, 1'b1, "comp late");
    pins.brightness_pwm_in <= 1'b0;
    cyc(10);
    chk_pwr(1'b0, 1'b0);
    chk_bit(ramp, 1'b1, "ramp on fall");
    chk_bit(pso, 1'b1, "off on fall");
    cyc(25);
    chk_bit(pso, 1'b1, "off held");
    cyc(30);
    chk_bit(pso, 1'b0, "off released");
    pins.brightness_pwm_in <= 1'b1;
    cyc(10);
    chk_bit(ramp, 1'b0, "ramp on rise");
  endtask

  task automatic sc_faults();
    pins.output_high_limit_sense <= 1'b1;
    cyc(10);
    chk_pwr(1'b0, 1'b0);
    wait_state(ST_FAULT);
    pins.output_high_limit_sense <= 1'b0;
    wait_state(ST_CLAMP);
    wait_state(ST_RUN);
    pins.output_low_limit_sense <= 1'b1;
    cyc(10);
    chk_pwr(1'b0, 1'b0);
    wait_state(ST_CLAMP);
    pins.output_low_limit_sense <= 1'b0;
    wait_state(ST_RUN);
    pins.cl_restart_trip <= 1'b1;
    pins.cl_release_ok <= 1'b0;
    cyc(10);
    chk_pwr(1'b0, 1'b0);
    wait_state(ST_FAULT);
    pins.cl_restart_trip <= 1'b0;
    cyc(20);
    wait_state(ST_FAULT);
    pins.cl_release_ok <= 1'b1;
    wait_state(ST_CLAMP);
    wait_state(ST_RUN);
  endtask

  task automatic sc_latch();
    logic [31:0] d;
    logic [1:0] r;
    pins.cl_latch_trip <= 1'b1;
    cyc(10);
    chk_pwr(1'b0, 1'b0);
    wait_state(ST_LATCH);
    pins.cl_latch_trip <= 1'b0;
    pins.output_high_limit_sense <= 1'b1;
    cyc(20);
    wait_state(ST_LATCH);
    pins.output_high_limit_sense <= 1'b0;
    cyc(300);
    wait_state(ST_LATCH);
    pins.supply_lockout <= 1'b1;
    wait_state(ST_OFF);
    pins.supply_lockout <= 1'b0;
    wait_state(ST_CLAMP);
    axi_wr({28'h000_0000, REG_CTRL}, 32'h0000_0000, r);
    wait_state(ST_OFF);
    axi_rd({28'h000_0000, REG_CTRL}, d, r);
    chk_word(d, 32'h0000_0000, "ctrl cleared");
    axi_wr({28'h000_0000, REG_CTRL}, CTRL_RST, r);
    wait_state(ST_CLAMP);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(6);
    sc_reset();
    sc_start();
    sc_dim();
    sc_faults();
    sc_latch();
    finish_test();
  end
endmodule
